// ### include/tibsr_pkg.sv
// Package with register map, field positions and reset values
package tibsr_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_FLAGS_FIRST = 8'h0a;
   localparam logic [7:0] ADDR_FLAGS_SECOND = 8'h0b;
   localparam logic [7:0] ADDR_FILL_LEVEL = 8'h0c;
   localparam logic [7:0] ADDR_HANDSHAKE = 8'h0d;
   localparam logic [7:0] ADDR_LAST_ADDR = 8'h0e;
   // Second flag register bit positions
   localparam int BIT_RX_START = 7;
   localparam int BIT_FRAME_ERR = 6;
   localparam int BIT_PARITY_ERR = 5;
   localparam int BIT_CRC_ERR = 4;
   localparam int BIT_BUFFER_FAULT = 3;
   localparam int BIT_EE_DONE = 2;
   localparam int BIT_EE_PROT_ERR = 1;
   localparam int BIT_ACCESS_ERR = 0;
   // Fill level fields
   localparam int BIT_LEN_INVALID = 7;
   localparam int LEN_WIDTH = 6;
   // Handshake fields
   localparam int BIT_READER_WORKING = 5;
   localparam int BIT_READER_DATA = 4;
   localparam int BIT_HOST_DATA = 3;
   localparam int BIT_UNDERFLOW = 1;
   localparam int BIT_OVERFLOW = 0;
   // Reset values, busy read pattern and zero read value
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] LAST_ADDR_RESET = 8'h00;
   localparam logic [7:0] LAST_ADDR_BUSY = 8'hff;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : tibsr_pkg

// ### design/tibsr_sync.sv
// Two-stage reset release synchroniser
`timescale 1ns/1ps
module tibsr_sync (
   // Clock and raw reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Synchronised reset
   output logic reset_sync_n
);
   logic [1:0] stage_reg;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= 2'h0;
      end else begin
         stage_reg <= {stage_reg[0], 1'b1};
      end
   end
   assign reset_sync_n = stage_reg[1];
endmodule : tibsr_sync

// ### design/tibsr_regs.sv
// Interrupt flag, buffer status and last reader address registers
// Operation
// - First flag register zeroed at reset, set-default, and after each host read.
// - Second flag register zeroed at reset, set-default, and after each host read.
// - Bit 7 sets when a reader frame starts into the buffer.
// - Bit 6 flags framing fault; bytes still stored in buffer.
// - Bit 5 flags parity mismatch; data still stored.
// - Bit 4 flags CRC failure; data still stored.
// - Bit 3 sets on buffer overflow or underflow.
// - Bit 2 sets when host-requested EEPROM programming completes.
// - Bit 1 sets on EEPROM write to protected or missing address.
// - Bit 0 sets when access control aborts a host operation.
// - Fill level bit 7 high while buffer contents change.
// - Fill level bits 5..0 hold unread byte count.
// - Fill level zeroed at reset, set-default and clear-buffer.
// - Handshake bits 5,4,3 report reader busy, reader data, host data.
// - Handshake bit 1 sets on buffer underflow.
// - Handshake bit 0 sets on buffer overflow.
// - Last-address register captures every reader EEPROM address, even out of range, except when clear-buffer or set-default comes in the same cycle.
// - Last-address reads all ones while being updated.
// - Masks gate only the interrupt output; flags still set.
`timescale 1ns/1ps
module tibsr_regs (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Device commands
   input wire logic cmd_set_default,
   input wire logic cmd_clear_buffer,
   // Host register read port
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   // First flag register events
   input wire logic [7:0] ev_first,
   // Second flag register events
   input wire logic ev_rx_start,
   input wire logic ev_frame_err,
   input wire logic ev_parity_err,
   input wire logic ev_crc_err,
   input wire logic ev_ee_done,
   input wire logic ev_ee_prot_err,
   input wire logic ev_access_err,
   // Buffer status
   input wire logic buf_changing,
   input wire logic [5:0] buf_count,
   input wire logic buf_count_load,
   input wire logic buf_underflow,
   input wire logic buf_overflow,
   input wire logic reader_side_working,
   input wire logic reader_side_data_waiting,
   input wire logic host_side_data_waiting,
   // Reader EEPROM access
   input wire logic rd_ee_start,
   input wire logic rd_ee_done,
   input wire logic [7:0] rd_ee_addr,
   // Masks
   input wire logic [7:0] mask_first,
   input wire logic [7:0] mask_second,
   // Interrupt
   output logic irq
);
   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
      logic len_invalid;
      logic [5:0] len;
      logic [2:0] hshake;
      logic under;
      logic over;
      logic addr_busy;
      logic [7:0] last_addr;
      logic [7:0] rd_data;
      logic irq;
   } tibsr_state_t;

   logic rst_n;
   tibsr_state_t st_reg;
   tibsr_state_t st_next;
   logic [7:0] ev_second;
   logic [7:0] first_v;
   logic [7:0] second_v;
   logic bf_event;

   tibsr_sync u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .reset_sync_n(rst_n)
   );

   always_comb begin
      st_next = st_reg;
      bf_event = buf_underflow | buf_overflow;
      ev_second = 8'h00;
      ev_second[tibsr_pkg::BIT_RX_START] = ev_rx_start;
      ev_second[tibsr_pkg::BIT_FRAME_ERR] = ev_frame_err;
      ev_second[tibsr_pkg::BIT_PARITY_ERR] = ev_parity_err;
      ev_second[tibsr_pkg::BIT_CRC_ERR] = ev_crc_err;
      ev_second[tibsr_pkg::BIT_BUFFER_FAULT] = bf_event;
      ev_second[tibsr_pkg::BIT_EE_DONE] = ev_ee_done;
      ev_second[tibsr_pkg::BIT_EE_PROT_ERR] = ev_ee_prot_err;
      ev_second[tibsr_pkg::BIT_ACCESS_ERR] = ev_access_err;
      // Read data
      st_next.rd_data = tibsr_pkg::READ_ZERO;
      if (rd_en) begin
         unique case (rd_addr)
            tibsr_pkg::ADDR_FLAGS_FIRST: st_next.rd_data = st_reg.first;
            tibsr_pkg::ADDR_FLAGS_SECOND: st_next.rd_data = st_reg.second;
            tibsr_pkg::ADDR_FILL_LEVEL: begin
               st_next.rd_data[tibsr_pkg::BIT_LEN_INVALID] = st_reg.len_invalid;
               st_next.rd_data[tibsr_pkg::LEN_WIDTH-1:0] = st_reg.len;
            end
            tibsr_pkg::ADDR_HANDSHAKE: begin
               st_next.rd_data[tibsr_pkg::BIT_READER_WORKING] = st_reg.hshake[2];
               st_next.rd_data[tibsr_pkg::BIT_READER_DATA] = st_reg.hshake[1];
               st_next.rd_data[tibsr_pkg::BIT_HOST_DATA] = st_reg.hshake[0];
               st_next.rd_data[tibsr_pkg::BIT_UNDERFLOW] = st_reg.under;
               st_next.rd_data[tibsr_pkg::BIT_OVERFLOW] = st_reg.over;
            end
            tibsr_pkg::ADDR_LAST_ADDR: begin
               st_next.rd_data = st_reg.addr_busy ? tibsr_pkg::LAST_ADDR_BUSY
                                                  : st_reg.last_addr;
            end
            default: st_next.rd_data = tibsr_pkg::READ_ZERO;
         endcase
      end
      // Read clears, new events win
      first_v = st_reg.first;
      second_v = st_reg.second;
      if (rd_en && rd_addr == tibsr_pkg::ADDR_FLAGS_FIRST) begin
         first_v = tibsr_pkg::FLAGS_RESET;
      end
      if (rd_en && rd_addr == tibsr_pkg::ADDR_FLAGS_SECOND) begin
         second_v = tibsr_pkg::FLAGS_RESET;
      end
      st_next.first = first_v | ev_first;
      st_next.second = second_v | ev_second;
      // Buffer status
      st_next.len_invalid = buf_changing;
      if (buf_count_load) begin
         st_next.len = buf_count;
      end
      st_next.hshake = {reader_side_working, reader_side_data_waiting,
                        host_side_data_waiting};
      st_next.under = st_reg.under | buf_underflow;
      st_next.over = st_reg.over | buf_overflow;
      // Last reader address
      if (rd_ee_start) begin
         st_next.addr_busy = 1'b1;
      end
      if (rd_ee_done) begin
         st_next.addr_busy = 1'b0;
         st_next.last_addr = rd_ee_addr;
      end
      if (cmd_clear_buffer) begin
         st_next.len = '0;
         st_next.len_invalid = 1'b0;
         st_next.under = 1'b0;
         st_next.over = 1'b0;
         st_next.last_addr = tibsr_pkg::LAST_ADDR_RESET;
         st_next.addr_busy = 1'b0;
      end
      if (cmd_set_default) begin
         st_next.first = tibsr_pkg::FLAGS_RESET;
         st_next.second = tibsr_pkg::FLAGS_RESET;
         st_next.len = '0;
         st_next.len_invalid = 1'b0;
         st_next.under = 1'b0;
         st_next.over = 1'b0;
         st_next.last_addr = tibsr_pkg::LAST_ADDR_RESET;
         st_next.addr_busy = 1'b0;
      end
      st_next.irq = |((st_next.first & ~mask_first) |
                      (st_next.second & ~mask_second));
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rd_data;
   assign irq = st_reg.irq;

   a_second_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && rd_addr == tibsr_pkg::ADDR_FLAGS_SECOND && !(|ev_second) && !cmd_set_default)
      |=> st_reg.second == 8'h00) else $error("second flags not cleared");
   a_first_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (rd_en && rd_addr == tibsr_pkg::ADDR_FLAGS_FIRST && ev_first == 8'h00)
      |=> st_reg.first == 8'h00) else $error("first flags not cleared");
   a_rx_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_rx_start && !cmd_set_default |=> st_reg.second[7]) else $error("rx start lost");
   a_crc_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_crc_err && !cmd_set_default |=> st_reg.second[4]) else $error("crc flag lost");
   a_bf_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (buf_underflow || buf_overflow) && !cmd_set_default |=> st_reg.second[3])
      else $error("buffer fault lost");
   a_underflow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      buf_underflow && !cmd_set_default && !cmd_clear_buffer |=> st_reg.under)
      else $error("underflow lost");
   a_len_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_clear_buffer |=> st_reg.len == 6'h00) else $error("length not cleared");
   a_addr_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && rd_addr == tibsr_pkg::ADDR_LAST_ADDR && st_reg.addr_busy
      |=> rd_data == tibsr_pkg::LAST_ADDR_BUSY)
      else $error("busy address not ones");
   a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      irq == |((st_reg.first & ~$past(mask_first)) | (st_reg.second & ~$past(mask_second))))
      else $error("irq does not follow unmasked flags");
   a_frame_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_frame_err && !cmd_set_default |=> st_reg.second[tibsr_pkg::BIT_FRAME_ERR])
      else $error("framing flag lost");
   a_parity_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_parity_err && !cmd_set_default |=> st_reg.second[tibsr_pkg::BIT_PARITY_ERR])
      else $error("parity flag lost");
   a_ee_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_ee_done && !cmd_set_default |=> st_reg.second[tibsr_pkg::BIT_EE_DONE])
      else $error("eeprom done flag lost");
   a_ee_prot: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_ee_prot_err && !cmd_set_default |=> st_reg.second[tibsr_pkg::BIT_EE_PROT_ERR])
      else $error("protection flag lost");
   a_access_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ev_access_err && !cmd_set_default |=> st_reg.second[tibsr_pkg::BIT_ACCESS_ERR])
      else $error("access flag lost");
   a_overflow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      buf_overflow && !cmd_set_default && !cmd_clear_buffer |=> st_reg.over)
      else $error("overflow lost");
   a_last_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_ee_done && !cmd_set_default && !cmd_clear_buffer
      |=> st_reg.last_addr == $past(rd_ee_addr))
      else $error("reader address not captured");
   a_hshake_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.hshake == $past({reader_side_working, reader_side_data_waiting,
                              host_side_data_waiting}))
      else $error("handshake levels not tracked");
   a_default_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_set_default |=> st_reg.first == tibsr_pkg::FLAGS_RESET
                          && st_reg.second == tibsr_pkg::FLAGS_RESET)
      else $error("flags not zeroed by set default");
endmodule : tibsr_regs

// ### bench/tibsr_host.sv
// Host model issuing register reads
`timescale 1ns/1ps
module tibsr_host (
   // Clock
   input wire logic clk_sys,
   // Read request
   output logic rd_en,
   output logic [7:0] rd_addr
);
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end
   // One read strobe; address scrambled once released
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      rd_addr <= ~a;
   endtask : rd
endmodule : tibsr_host

// ### bench/testbench.sv
// Self-checking bench for the status register group
`timescale 1ns/1ps
module testbench;
   logic clk_sys, reset_n, rd_en, irq, chg, pend;
   logic [7:0] rd_addr, rd_data, f, msk, ea, r;
   logic [15:0] p;
   logic [5:0] cnt;
   logic [2:0] lv;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h3;
   int n_fail = 0;
   int n_checks = 0;
   tibsr_host host (.clk_sys(clk_sys), .rd_en(rd_en), .rd_addr(rd_addr));
   tibsr_regs DUT (.clk_sys(clk_sys), .reset_n(reset_n), .cmd_set_default(p[9]),
      .cmd_clear_buffer(p[10]), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .ev_first(f), .ev_rx_start(p[7]), .ev_frame_err(p[6]), .ev_parity_err(p[5]),
      .ev_crc_err(p[4]), .ev_ee_done(p[2]), .ev_ee_prot_err(p[1]), .ev_access_err(p[0]),
      .buf_changing(chg), .buf_count(cnt), .buf_count_load(p[13]),
      .buf_underflow(p[8]), .buf_overflow(p[3]), .reader_side_working(lv[2]),
      .reader_side_data_waiting(lv[1]), .host_side_data_waiting(lv[0]),
      .rd_ee_start(p[11]), .rd_ee_done(p[12]), .rd_ee_addr(ea), .mask_first(msk),
      .mask_second(msk), .irq(irq));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task cmp(input logic [7:0] got, input logic [7:0] e);
      n_checks++;
      if (got !== e) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
      end
   endtask : cmp
   task chk(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : chk
   task pulse(input int k);
      @(posedge clk_sys);
      p[k] <= 1'b1;
      @(posedge clk_sys);
      p <= 16'h0000;
   endtask : pulse
   task print_verdict;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Result watcher
   always @(posedge clk_sys) begin
      if (pend === 1'b1) cmp(rd_data, exp_q.pop_front());
      pend <= rd_en;
   end
   initial begin
      #(25 * 6000);
      n_fail++;
      print_verdict();
   end
   initial begin
      {reset_n, chg, pend, f, msk, ea, p, cnt, lv} = '0;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Reset values, an unmapped address, and first-flag set then read-clear
      for (int i = 0; i < 6; i++) chk(8'h0a + i[7:0], 8'h00);
      r = 8'(xs());
      @(posedge clk_sys);
      f <= r;
      @(posedge clk_sys);
      f <= 8'h00;
      chk(8'h0a, r);
      chk(8'h0a, 8'h00);
      // Every second-flag event bit, odd bits masked and even bits unmasked
      for (int k = 7; k >= 0; k--) begin
         msk <= k[0] ? 8'hff : 8'h00;
         pulse(k);
         @(posedge clk_sys);
         cmp({7'h00, irq}, {7'h00, ~k[0]});
         chk(8'h0b, 8'h01 << k);
         chk(8'h0b, 8'h00);
         @(posedge clk_sys);
         cmp({7'h00, irq}, 8'h00);
      end
      // Handshake levels and sticky underflow/overflow
      lv <= 3'b111;
      pulse(8);
      chk(8'h0d, 8'h3b);
      chk(8'h0b, 8'h08);
      pulse(10);
      chk(8'h0d, 8'h38);
      lv <= 3'b000;
      // Fill level
      cnt <= 6'(xs());
      pulse(13);
      chk(8'h0c, {2'b00, cnt});
      chg <= 1'b1;
      chk(8'h0c, {2'b10, cnt});
      chg <= 1'b0;
      pulse(10);
      chk(8'h0c, 8'h00);
      // Last reader address, then set-default clearing a CRC flag
      pulse(11);
      chk(8'h0e, 8'hff);
      ea <= 8'(xs());
      pulse(12);
      chk(8'h0e, ea);
      pulse(10);
      chk(8'h0e, 8'h00);
      pulse(4);
      pulse(9);
      chk(8'h0b, 8'h00);
      repeat (3) @(posedge clk_sys);
      print_verdict();
   end
endmodule : testbench
